//--- shared/fsic_pkg.sv
// constants for the frame-sync, interrupt-clear and fifo readout configuration block
package fsic_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FSIC_ADDR_FIFO_READOUT_CONFIG = 8'h02;
    localparam logic [7:0] FSIC_ADDR_FRAME_SYNC_CONFIG = 8'h03;
    localparam logic [7:0] FSIC_ADDR_INTERRUPT_CLEAR_CONFIG = 8'h04;
    localparam logic [7:0] FSIC_ADDR_FIFO_DATA = 8'h3F;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FSIC_RST_FIFO_READOUT_CONFIG = 8'h00;
    localparam logic [7:0] FSIC_RST_FRAME_SYNC_CONFIG = 8'h00;
    localparam logic [7:0] FSIC_RST_INTERRUPT_CLEAR_CONFIG = 8'h00;
    // ------------------------------------------------------------
    // writable bit masks, reserved bits read zero
    // ------------------------------------------------------------
    localparam logic [7:0] FSIC_MASK_FIFO_READOUT_CONFIG = 8'h11;
    localparam logic [7:0] FSIC_MASK_FRAME_SYNC_CONFIG = 8'h73;
    localparam logic [7:0] FSIC_MASK_INTERRUPT_CLEAR_CONFIG = 8'h3F;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FSIC_POS_EMPTY_MARKER_DISABLE = 4;
    localparam int FSIC_POS_OSC_WAKE_DISABLE = 0;
    localparam int FSIC_POS_TAG_SELECT_LO = 4;
    localparam int FSIC_POS_FLAG_CLEAR_SELECT = 1;
    localparam int FSIC_POS_EDGE_SELECT = 0;
    localparam int FSIC_POS_DRDY_CLEAR_LO = 4;
    localparam int FSIC_POS_THS_CLEAR_LO = 2;
    localparam int FSIC_POS_FULL_CLEAR_LO = 0;
    // ------------------------------------------------------------
    // values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] FSIC_EMPTY_MARKER = 8'hFF;
    localparam int FSIC_NUM_OUTPUTS = 7;
    localparam logic [2:0] FSIC_TAG_NONE = 3'h0;
    localparam logic [1:0] FSIC_CLR_DATA_READ = 2'h2;
    localparam logic [1:0] FSIC_CLR_EITHER = 2'h3;
endpackage

//--- core/fsic_frame_sync_input_tag.sv
// frame-sync edge detection and per-output tag flag
`timescale 1ns/1ps
`default_nettype none
module fsic_frame_sync_input_tag (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // configuration
    input wire logic [2:0] i_tag_select,
    input wire logic i_clear_on_lsb_read,
    input wire logic i_edge_falling,
    // events
    input wire logic i_frame_sync_input,
    input wire logic i_sample_update,
    input wire logic [fsic_pkg::FSIC_NUM_OUTPUTS-1:0] i_lsb_read,
    // results
    output logic o_interval_start,
    output logic [fsic_pkg::FSIC_NUM_OUTPUTS-1:0] o_tag_lsb
);
    import fsic_pkg::*;

    logic pin_prev_q;
    logic start_q;
    logic flag_q;
    logic rise;
    logic fall;
    logic edge_hit;
    logic flag_clear;

    // ------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------
    assign rise = i_frame_sync_input & ~pin_prev_q;
    assign fall = ~i_frame_sync_input & pin_prev_q;
    assign edge_hit = i_edge_falling ? fall : rise; // see RL11
    // index 0 is temperature, tag code n maps to index n-1
    assign flag_clear = i_clear_on_lsb_read
                        ? |({i_lsb_read, 1'b0} & (8'h01 << i_tag_select)) // see RL10
                        : i_sample_update; // see RL9

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_prev_q <= 1'b0;
            start_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            pin_prev_q <= i_frame_sync_input;
            start_q <= edge_hit;
            // set wins over clear
            if (edge_hit) begin
                flag_q <= 1'b1;
            end else if (flag_clear) begin
                flag_q <= 1'b0;
            end
        end
    end

    assign o_interval_start = start_q;

    // ------------------------------------------------------------
    // one tag bit per output
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < FSIC_NUM_OUTPUTS; g = g + 1) begin : g_tag
            logic tag_q;
            always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    tag_q <= 1'b0;
                end else begin
                    // code 000 matches no output, so nothing is tagged
                    tag_q <= flag_q && (i_tag_select != FSIC_TAG_NONE)
                             && (i_tag_select == 3'(g + 1)); // see RL7, RL8
                end
            end
            assign o_tag_lsb[g] = tag_q;
        end
    endgenerate
endmodule
`default_nettype wire

//--- core/fsic_top.sv
// configuration registers for fifo readout, frame-sync tagging and interrupt clears
//
// Overview of operation
// RL1: with the empty-marker disable bit low, reading an empty fifo returns 0xFF.
// RL2: with that bit high, reading an empty fifo returns the last delivered fifo byte.
// RL3: with wake disable low, watermark enabled and low-power wake mode, watermark starts the oscillator.
// RL4: an oscillator started by watermark stays on until the host reads the fifo.
// RL5: with wake disable high, a watermark never starts the oscillator.
// RL6: the host keeps wake disable high outside low-power wake mode and restores it 1 ODR before leaving.
// RL7: tag select code 000 tags no sensor output.
// RL8: tag select codes 001 to 111 place the flag on temperature, gyro x/y/z, accel x/y/z.
// RL9: with flag clear select low, the flag clears when a new sample updates the outputs.
// RL10: with flag clear select high, the flag clears when the host reads the tagged lsb.
// RL11: the edge select bit picks rising (0) or falling (1) edge to start interval timing.
// RL12: data-ready clear codes 00/01 use status read, 10 sensor read, 11 either.
// RL13: fifo-threshold clear codes 00/01 use status read, 10 fifo byte read, 11 either.
// RL14: fifo-full clear codes 00/01 use status read, 10 fifo byte read, 11 either.
// RL15: reserved bits read zero and writes to them have no effect.
`timescale 1ns/1ps
`default_nettype none
module fsic_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // host register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // fifo storage side
    input wire logic i_fifo_empty,
    input wire logic [7:0] i_fifo_data,
    output logic o_fifo_pop,
    // oscillator control
    input wire logic i_watermark_reached,
    input wire logic i_watermark_irq_enable,
    input wire logic i_accel_low_power_mode,
    input wire logic i_on_wake_up_oscillator,
    output logic o_system_oscillator_req,
    // frame sync and sensor outputs
    input wire logic i_frame_sync_input,
    input wire logic i_sample_update,
    input wire logic [fsic_pkg::FSIC_NUM_OUTPUTS-1:0] i_sensor_lsb_read,
    input wire logic i_sensor_reg_read,
    output logic o_frame_sync_interval_start,
    output logic [fsic_pkg::FSIC_NUM_OUTPUTS-1:0] o_frame_sync_tag_lsb,
    // latched interrupt clears
    input wire logic i_status_read,
    output logic o_data_ready_irq_clear,
    output logic o_fifo_threshold_irq_clear,
    output logic o_fifo_full_irq_clear
);
    import fsic_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] fifo_readout_config_q;
    logic [7:0] frame_sync_config_q;
    logic [7:0] interrupt_clear_config_q;
    logic [7:0] last_fifo_byte_q;
    logic [7:0] rdata_q;
    logic pop_q;
    logic osc_req_q;
    logic drdy_clr_q;
    logic ths_clr_q;
    logic full_clr_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic sel_readout;
    logic sel_frame_sync_input;
    logic sel_intclr;
    logic sel_fifo_data;
    logic fifo_byte_read;

    assign sel_readout = (i_reg_addr == FSIC_ADDR_FIFO_READOUT_CONFIG);
    assign sel_frame_sync_input = (i_reg_addr == FSIC_ADDR_FRAME_SYNC_CONFIG);
    assign sel_intclr = (i_reg_addr == FSIC_ADDR_INTERRUPT_CLEAR_CONFIG);
    assign sel_fifo_data = (i_reg_addr == FSIC_ADDR_FIFO_DATA);
    assign fifo_byte_read = i_reg_rd & sel_fifo_data;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    logic empty_marker_disable;
    logic osc_wake_on_watermark_disable;
    logic [2:0] frame_sync_tag_select;
    logic frame_sync_flag_clear_select;
    logic frame_sync_edge_select;
    logic [1:0] data_ready_irq_clear_select;
    logic [1:0] fifo_threshold_irq_clear_select;
    logic [1:0] fifo_full_irq_clear_select;

    assign empty_marker_disable = fifo_readout_config_q[FSIC_POS_EMPTY_MARKER_DISABLE];
    assign osc_wake_on_watermark_disable = fifo_readout_config_q[FSIC_POS_OSC_WAKE_DISABLE];
    assign frame_sync_tag_select = frame_sync_config_q[FSIC_POS_TAG_SELECT_LO +: 3];
    assign frame_sync_flag_clear_select = frame_sync_config_q[FSIC_POS_FLAG_CLEAR_SELECT];
    assign frame_sync_edge_select = frame_sync_config_q[FSIC_POS_EDGE_SELECT];
    assign data_ready_irq_clear_select = interrupt_clear_config_q[FSIC_POS_DRDY_CLEAR_LO +: 2];
    assign fifo_threshold_irq_clear_select = interrupt_clear_config_q[FSIC_POS_THS_CLEAR_LO +: 2];
    assign fifo_full_irq_clear_select = interrupt_clear_config_q[FSIC_POS_FULL_CLEAR_LO +: 2];

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [7:0] fifo_read_value;
    logic [7:0] empty_value;
    logic [7:0] read_value;

    assign empty_value = empty_marker_disable ? last_fifo_byte_q // see RL2
                                              : FSIC_EMPTY_MARKER; // see RL1
    assign fifo_read_value = i_fifo_empty ? empty_value : i_fifo_data;
    assign read_value = sel_readout ? fifo_readout_config_q
                      : sel_frame_sync_input ? frame_sync_config_q
                      : sel_intclr ? interrupt_clear_config_q
                      : sel_fifo_data ? fifo_read_value
                      : 8'h00;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // writes are masked so reserved bits hold zero
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fifo_readout_config_q <= FSIC_RST_FIFO_READOUT_CONFIG;
            frame_sync_config_q <= FSIC_RST_FRAME_SYNC_CONFIG;
            interrupt_clear_config_q <= FSIC_RST_INTERRUPT_CLEAR_CONFIG;
        end else if (i_reg_wr) begin
            if (sel_readout) begin
                fifo_readout_config_q <= i_reg_wdata & FSIC_MASK_FIFO_READOUT_CONFIG; // see RL15
            end
            if (sel_frame_sync_input) begin
                frame_sync_config_q <= i_reg_wdata & FSIC_MASK_FRAME_SYNC_CONFIG; // see RL15
            end
            if (sel_intclr) begin
                interrupt_clear_config_q <= i_reg_wdata & FSIC_MASK_INTERRUPT_CLEAR_CONFIG; // see RL15
            end
        end
    end

    // ------------------------------------------------------------
    // host read path and fifo pop
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
            pop_q <= 1'b0;
            last_fifo_byte_q <= 8'h00;
        end else begin
            pop_q <= fifo_byte_read & ~i_fifo_empty;
            if (i_reg_rd) begin
                rdata_q <= read_value;
            end
            // empty reads leave the remembered byte alone
            if (fifo_byte_read && !i_fifo_empty) begin
                last_fifo_byte_q <= i_fifo_data;
            end
        end
    end

    // ------------------------------------------------------------
    // system oscillator wake on watermark
    // ------------------------------------------------------------
    // wake request costs power; software is expected to keep it off
    // outside low-power wake mode (see RL6)
    logic osc_wake;

    assign osc_wake = ~osc_wake_on_watermark_disable // see RL3, RL5
                      & i_watermark_irq_enable
                      & i_accel_low_power_mode
                      & i_on_wake_up_oscillator
                      & i_watermark_reached;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osc_req_q <= 1'b0;
        end else if (osc_wake) begin
            osc_req_q <= 1'b1; // see RL3
        end else if (fifo_byte_read) begin
            osc_req_q <= 1'b0; // see RL4
        end
    end

    // ------------------------------------------------------------
    // latched interrupt clear sources
    // ------------------------------------------------------------
    logic drdy_clr;
    logic ths_clr;
    logic full_clr;

    // codes 00 and 01 both mean status read
    assign drdy_clr = (data_ready_irq_clear_select == FSIC_CLR_DATA_READ) ? i_sensor_reg_read
                    : (data_ready_irq_clear_select == FSIC_CLR_EITHER)
                      ? (i_status_read | i_sensor_reg_read)
                    : i_status_read; // see RL12
    assign ths_clr = (fifo_threshold_irq_clear_select == FSIC_CLR_DATA_READ) ? fifo_byte_read
                   : (fifo_threshold_irq_clear_select == FSIC_CLR_EITHER)
                     ? (i_status_read | fifo_byte_read)
                   : i_status_read; // see RL13
    assign full_clr = (fifo_full_irq_clear_select == FSIC_CLR_DATA_READ) ? fifo_byte_read
                    : (fifo_full_irq_clear_select == FSIC_CLR_EITHER)
                      ? (i_status_read | fifo_byte_read)
                    : i_status_read; // see RL14

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            drdy_clr_q <= 1'b0;
            ths_clr_q <= 1'b0;
            full_clr_q <= 1'b0;
        end else begin
            drdy_clr_q <= drdy_clr;
            ths_clr_q <= ths_clr;
            full_clr_q <= full_clr;
        end
    end

    // ------------------------------------------------------------
    // frame-sync tagging
    // ------------------------------------------------------------
    fsic_frame_sync_input_tag u_frame_sync_input_tag (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_tag_select(frame_sync_tag_select),
        .i_clear_on_lsb_read(frame_sync_flag_clear_select),
        .i_edge_falling(frame_sync_edge_select),
        .i_frame_sync_input(i_frame_sync_input),
        .i_sample_update(i_sample_update),
        .i_lsb_read(i_sensor_lsb_read),
        .o_interval_start(o_frame_sync_interval_start),
        .o_tag_lsb(o_frame_sync_tag_lsb)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = rdata_q;
    assign o_fifo_pop = pop_q;
    assign o_system_oscillator_req = osc_req_q;
    assign o_data_ready_irq_clear = drdy_clr_q;
    assign o_fifo_threshold_irq_clear = ths_clr_q;
    assign o_fifo_full_irq_clear = full_clr_q;
endmodule
`default_nettype wire

//--- verif/fsic_monitor.sv
// port-level assertions for the configuration block
`timescale 1ns/1ps
`default_nettype none
module fsic_monitor (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // host port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // fifo and oscillator
    input wire logic i_fifo_empty,
    input wire logic [7:0] i_fifo_data,
    input wire logic i_watermark_reached,
    input wire logic i_watermark_irq_enable,
    input wire logic i_accel_low_power_mode,
    input wire logic i_on_wake_up_oscillator,
    input wire logic o_system_oscillator_req,
    // frame sync and clears
    input wire logic i_frame_sync_input,
    input wire logic o_frame_sync_interval_start,
    input wire logic [fsic_pkg::FSIC_NUM_OUTPUTS-1:0] o_frame_sync_tag_lsb,
    input wire logic i_status_read,
    input wire logic i_sensor_reg_read,
    input wire logic o_data_ready_irq_clear,
    input wire logic o_fifo_threshold_irq_clear,
    input wire logic o_fifo_full_irq_clear
);
    import fsic_pkg::*;
    // shadow of the config registers, rebuilt from host writes
    logic [7:0] c02_q, c03_q, c04_q, last_q;
    logic pin_q;
    wire logic fifo_rd = i_reg_rd && (i_reg_addr == FSIC_ADDR_FIFO_DATA);
    wire logic wake = i_watermark_reached && i_watermark_irq_enable && i_accel_low_power_mode
        && i_on_wake_up_oscillator && !c02_q[0];
    wire logic edge_hit = c03_q[0] ? (pin_q && !i_frame_sync_input) : (!pin_q && i_frame_sync_input);
    wire logic [2:0] sel = c03_q[6:4];
    wire logic drdy_exp = (i_status_read && c04_q[5:4] != 2'h2) || (i_sensor_reg_read && c04_q[5]);
    wire logic ths_exp = (i_status_read && c04_q[3:2] != 2'h2) || (fifo_rd && c04_q[3]);
    wire logic full_exp = (i_status_read && c04_q[1:0] != 2'h2) || (fifo_rd && c04_q[1]);
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {c02_q, c03_q, c04_q, last_q, pin_q} <= '0;
        end else begin
            pin_q <= i_frame_sync_input;
            if (i_reg_wr && i_reg_addr == FSIC_ADDR_FIFO_READOUT_CONFIG) c02_q <= i_reg_wdata & 8'h11;
            if (i_reg_wr && i_reg_addr == FSIC_ADDR_FRAME_SYNC_CONFIG) c03_q <= i_reg_wdata & 8'h73;
            if (i_reg_wr && i_reg_addr == FSIC_ADDR_INTERRUPT_CLEAR_CONFIG) c04_q <= i_reg_wdata & 8'h3F;
            if (fifo_rd && !i_fifo_empty) last_q <= i_fifo_data;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_empty_marker: assert property (fifo_rd && i_fifo_empty && !c02_q[4] |=> o_reg_rdata == 8'hFF)
        else $error("empty read gave no marker");
    a_last_byte: assert property (fifo_rd && i_fifo_empty && c02_q[4] |=> o_reg_rdata == $past(last_q))
        else $error("empty read lost last byte");
    a_osc_wake: assert property (wake |=> o_system_oscillator_req)
        else $error("watermark did not wake oscillator");
    a_osc_hold: assert property (o_system_oscillator_req && !fifo_rd |=> o_system_oscillator_req)
        else $error("oscillator request dropped early");
    a_osc_release: assert property (fifo_rd && !wake |=> !o_system_oscillator_req)
        else $error("oscillator request kept after read");
    a_osc_quiet: assert property (!o_system_oscillator_req && !wake |=> !o_system_oscillator_req)
        else $error("oscillator request without wake");
    a_tag_none: assert property (sel == 3'h0 |=> o_frame_sync_tag_lsb == 7'h00)
        else $error("tag shown while tagging off");
    a_tag_place: assert property (sel != 3'h0 |=> (o_frame_sync_tag_lsb & ~(7'h01 << ($past(sel) - 3'h1))) == 7'h00)
        else $error("tag on wrong output");
    a_edge_start: assert property (edge_hit |=> o_frame_sync_interval_start)
        else $error("selected edge gave no start");
    a_no_false_start: assert property (!edge_hit |=> !o_frame_sync_interval_start)
        else $error("start without selected edge");
    a_drdy_clear: assert property (1'b1 |=> o_data_ready_irq_clear == $past(drdy_exp))
        else $error("data ready clear wrong");
    a_ths_clear: assert property (1'b1 |=> o_fifo_threshold_irq_clear == $past(ths_exp))
        else $error("threshold clear wrong");
    a_full_clear: assert property (1'b1 |=> o_fifo_full_irq_clear == $past(full_exp))
        else $error("full clear wrong");
    a_reserved_zero: assert property (i_reg_rd && i_reg_addr == 8'h03 |=> (o_reg_rdata & 8'h8C) == 8'h00)
        else $error("reserved bits read nonzero");
    c_osc: cover property ($rose(o_system_oscillator_req));
    c_start: cover property (o_frame_sync_interval_start);
    c_tag: cover property (o_frame_sync_tag_lsb != 7'h00);
endmodule
bind fsic_top fsic_monitor u_mon (.*);
`default_nettype wire

//--- verif/fsic_host_model.sv
// host register access model for the block's register port
`timescale 1ns/1ps
`default_nettype none
module fsic_host_model (
    // clock
    input wire logic i_clk_sys,
    // register port
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata
);
    initial begin
        {o_reg_addr, o_reg_wr, o_reg_rd, o_reg_wdata} = '0;
    end
    // released address and data are inverted so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        {o_reg_addr, o_reg_wdata, o_reg_wr} = {a, d, 1'b1};
        @(posedge i_clk_sys);
        #1;
        {o_reg_addr, o_reg_wdata, o_reg_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        {o_reg_addr, o_reg_rd} = {a, 1'b1};
        @(posedge i_clk_sys);
        #1;
        d = i_reg_rdata;
        {o_reg_addr, o_reg_rd} = {~a, 1'b0};
    endtask
endmodule
`default_nettype wire

//--- verif/fsic_top_tb_top.sv
// directed testbench for the configuration block
`timescale 1ns/1ps
`default_nettype none
module fsic_top_tb_top;
    import fsic_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_fifo_data, rd_q;
    logic i_reg_wr, i_reg_rd, i_fifo_empty, o_fifo_pop, o_system_oscillator_req;
    logic i_watermark_reached, i_watermark_irq_enable, i_accel_low_power_mode;
    logic i_on_wake_up_oscillator, i_frame_sync_input, i_sample_update, i_sensor_reg_read;
    logic i_status_read, o_frame_sync_interval_start;
    logic o_data_ready_irq_clear, o_fifo_threshold_irq_clear, o_fifo_full_irq_clear;
    logic [6:0] i_sensor_lsb_read, o_frame_sync_tag_lsb;
    logic [7:0] cfg_a [3] = '{8'h02, 8'h03, 8'h04};
    logic [7:0] cfg_m [3] = '{8'h11, 8'h73, 8'h3F};
    int err_total = 0;
    int n_compared = 0, starts;
    always #25 i_clk_sys = ~i_clk_sys;
    fsic_top uut (.*);
    fsic_host_model host (.i_clk_sys(i_clk_sys), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
        .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata));
    // one-byte fifo, empties on pop
    always @(posedge i_clk_sys) begin
        if (o_fifo_pop === 1'b1) begin
            #1;
            {i_fifo_empty, i_fifo_data} = {1'b1, ~i_fifo_data};
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic strobe(input logic [3:0] v, input logic [6:0] l);
        @(posedge i_clk_sys);
        #1;
        {i_watermark_reached, i_sample_update, i_sensor_reg_read, i_status_read} = v;
        i_sensor_lsb_read = l;
        @(posedge i_clk_sys);
        #1;
        {i_watermark_reached, i_sample_update, i_sensor_reg_read, i_status_read} = 4'h0;
        i_sensor_lsb_read = 7'h00;
    endtask
    task automatic set_pin(input logic v);
        @(posedge i_clk_sys);
        #1;
        i_frame_sync_input = v;
    endtask
    task automatic count_starts(input int n);
        starts = 0;
        repeat (n) begin
            @(posedge i_clk_sys);
            #2;
            if (o_frame_sync_interval_start === 1'b1) starts++;
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {i_fifo_empty, i_fifo_data, i_sensor_lsb_read} = {1'b1, 8'h00, 7'h00};
        {i_watermark_reached, i_sample_update, i_sensor_reg_read, i_status_read} = 4'h0;
        {i_watermark_irq_enable, i_accel_low_power_mode, i_on_wake_up_oscillator} = 3'h0;
        i_frame_sync_input = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_reset_n = 1'b1;
        for (int k = 0; k < 3; k++) begin
            host.rd(cfg_a[k], rd_q);
            check(rd_q, 8'h00);
            host.wr(cfg_a[k], 8'hFF);
            host.rd(cfg_a[k], rd_q);
            check(rd_q, cfg_m[k]);
        end
        host.wr(8'h10, 8'hFF);
        host.rd(8'h10, rd_q);
        check(rd_q, 8'h00);
        $display("test registers done");
        host.wr(FSIC_ADDR_FIFO_READOUT_CONFIG, 8'h00);
        host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
        check(rd_q, 8'hFF);
        {i_fifo_empty, i_fifo_data} = {1'b0, 8'h5A};
        host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
        check(rd_q, 8'h5A);
        check({7'h00, o_fifo_pop}, 8'h01);
        host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
        check(rd_q, 8'hFF);
        host.wr(FSIC_ADDR_FIFO_READOUT_CONFIG, 8'h10);
        host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
        check(rd_q, 8'h5A);
        $display("test fifo readout done");
        host.wr(FSIC_ADDR_FIFO_READOUT_CONFIG, 8'h00);
        {i_watermark_irq_enable, i_accel_low_power_mode, i_on_wake_up_oscillator} = 3'h7;
        strobe(4'h8, 7'h00);
        check({7'h00, o_system_oscillator_req}, 8'h01);
        #200;
        check({7'h00, o_system_oscillator_req}, 8'h01);
        host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
        check({7'h00, o_system_oscillator_req}, 8'h00);
        host.wr(FSIC_ADDR_FIFO_READOUT_CONFIG, 8'h01);
        strobe(4'h8, 7'h00);
        check({7'h00, o_system_oscillator_req}, 8'h00);
        $display("test oscillator done");
        for (int s = 0; s < 8; s++) begin
            host.wr(FSIC_ADDR_FRAME_SYNC_CONFIG, {1'b0, 3'(s), 4'h2});
            set_pin(1'b1);
            count_starts(3);
            check(8'(starts), 8'h01);
            strobe(4'h4, 7'h00);
            check({1'b0, o_frame_sync_tag_lsb}, s == 0 ? 8'h00 : 8'h01 << (s - 1));
            strobe(4'h0, s == 0 ? 7'h00 : 7'h01 << (s - 1));
            set_pin(1'b0);
            #100;
            check({1'b0, o_frame_sync_tag_lsb}, 8'h00);
        end
        host.wr(FSIC_ADDR_FRAME_SYNC_CONFIG, 8'h13);
        set_pin(1'b1);
        count_starts(3);
        check(8'(starts), 8'h00);
        set_pin(1'b0);
        count_starts(3);
        check(8'(starts), 8'h01);
        host.wr(FSIC_ADDR_FRAME_SYNC_CONFIG, 8'h10);
        set_pin(1'b1);
        count_starts(3);
        check({1'b0, o_frame_sync_tag_lsb}, 8'h01);
        strobe(4'h4, 7'h00);
        @(posedge i_clk_sys);
        #1;
        check({1'b0, o_frame_sync_tag_lsb}, 8'h00);
        set_pin(1'b0);
        $display("test frame sync done");
        for (int c = 0; c < 4; c++) begin
            host.wr(FSIC_ADDR_INTERRUPT_CLEAR_CONFIG, {2'b00, 2'(c), 2'(c), 2'(c)});
            strobe(4'h1, 7'h00);
            check({5'h00, o_data_ready_irq_clear, o_fifo_threshold_irq_clear,
                o_fifo_full_irq_clear}, c == 2 ? 8'h00 : 8'h07);
            strobe(4'h2, 7'h00);
            check({5'h00, o_data_ready_irq_clear, o_fifo_threshold_irq_clear,
                o_fifo_full_irq_clear}, c >= 2 ? 8'h04 : 8'h00);
            host.rd(FSIC_ADDR_FIFO_DATA, rd_q);
            check({5'h00, o_data_ready_irq_clear, o_fifo_threshold_irq_clear,
                o_fifo_full_irq_clear}, c >= 2 ? 8'h03 : 8'h00);
        end
        $display("test interrupt clears done");
        wrap_up();
    end
endmodule
`default_nettype wire
